// ---- core/quad_bit_io_ports.sv ----
// Nibble-wide I/O ports with whole-nibble access, single-bit operations and standby wake.
//
// Summary of operation
// - Reading a port register returns the four pin levels of that port as one nibble.
// - Writing a port register loads all four output latches of that port at once.
// - The two branch tests look at one chosen pin and report taken when it is set or clear.
// - Bit set and bit clear change exactly one output latch and leave the other three alone.
// - Bit 3 of the first port is the standby wake input that ends the halted state.
// - Each pin is fixed by option as open-drain or as output with built-in pull-up.
// - The second and third ports drive an option-selected high or low level during reset.
// - That reset level is chosen for all four bits of a port together.
// - The second port offers the same nibble and bit functions but no standby wake.
// - The third port behaves exactly like the second, reset level option included.
// - Serial in, serial out, serial clock and external interrupt share the fourth port pins.
`timescale 1ns/1ps
module quad_bit_io_ports #(
  parameter logic [3:0] OPEN_DRAIN_A = 4'hF,
  parameter logic [3:0] OPEN_DRAIN_C = 4'hF,
  parameter logic [3:0] OPEN_DRAIN_D = 4'hF,
  parameter logic [3:0] OPEN_DRAIN_F = 4'hF,
  parameter logic RESET_HIGH_C = 1'b1,
  parameter logic RESET_HIGH_D = 1'b1
) (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic [quad_io_pkg::NIB_W-1:0] FIRST_NIBBLE_PORT_I,
  output logic [quad_io_pkg::NIB_W-1:0] FIRST_NIBBLE_PORT_O,
  output logic [quad_io_pkg::NIB_W-1:0] FIRST_NIBBLE_PORT_OE_B_O,
  output logic [quad_io_pkg::NIB_W-1:0] FIRST_NIBBLE_PULLUP_O,
  input wire logic [quad_io_pkg::NIB_W-1:0] SECOND_NIBBLE_PORT_I,
  output logic [quad_io_pkg::NIB_W-1:0] SECOND_NIBBLE_PORT_O,
  output logic [quad_io_pkg::NIB_W-1:0] SECOND_NIBBLE_PORT_OE_B_O,
  output logic [quad_io_pkg::NIB_W-1:0] SECOND_NIBBLE_PULLUP_O,
  input wire logic [quad_io_pkg::NIB_W-1:0] THIRD_NIBBLE_PORT_I,
  output logic [quad_io_pkg::NIB_W-1:0] THIRD_NIBBLE_PORT_O,
  output logic [quad_io_pkg::NIB_W-1:0] THIRD_NIBBLE_PORT_OE_B_O,
  output logic [quad_io_pkg::NIB_W-1:0] THIRD_NIBBLE_PULLUP_O,
  input wire logic [quad_io_pkg::NIB_W-1:0] SHARED_SERIAL_PORT_I,
  output logic [quad_io_pkg::NIB_W-1:0] SHARED_SERIAL_PORT_O,
  output logic [quad_io_pkg::NIB_W-1:0] SHARED_SERIAL_PORT_OE_B_O,
  output logic [quad_io_pkg::NIB_W-1:0] SHARED_SERIAL_PULLUP_O,
  input wire logic SER_DATA_OUT_I,
  input wire logic SER_CLK_OUT_I,
  input wire logic SER_CLK_DRIVE_I,
  output logic SER_DATA_IN_O,
  output logic SER_CLK_IN_O,
  output logic EXT_INT_REQ_B_O,
  output logic HALTED_O
);
  import quad_io_pkg::*;

  typedef struct packed {
    logic [NUM_PORTS-1:0][NIB_W-1:0] latch;
    logic [NIB_W-1:0] func_sel;
    run_state_t run_st;
    logic taken;
    logic pin_seen;
    logic ack;
    logic [31:0] rdata;
  } port_state_t;

  localparam logic [3:0] RST_LATCH_C = {4{RESET_HIGH_C}};
  localparam logic [3:0] RST_LATCH_D = {4{RESET_HIGH_D}};

  localparam port_state_t ST_RST = '{
    latch: {RST_LATCH_F, RST_LATCH_D, RST_LATCH_C, RST_LATCH_A},
    func_sel: RST_FUNC_SEL,
    run_st: RUN_ST,
    taken: 1'b0,
    pin_seen: 1'b0,
    ack: 1'b0,
    rdata: 32'h0000_0000
  };

  port_state_t st_r;
  port_state_t st_nxt;

  logic [NIB_W-1:0] pin_raw [NUM_PORTS];
  logic [NIB_W-1:0] pin_lvl [NUM_PORTS];
  logic req;
  logic wr_en;
  logic rd_en;
  logic [1:0] cmd_port;
  logic [1:0] cmd_bit;
  bit_op_t cmd_op;
  logic [NIB_W-1:0] f_drive;

  function automatic logic [NIB_W-1:0] bit_mask(input logic [1:0] idx);
    logic [NIB_W-1:0] m;
    m = 4'h0;
    m[idx] = 1'b1;
    return m;
  endfunction : bit_mask

  function automatic logic [NIB_W-1:0] port_of_addr(input logic [7:0] adr);
    logic [NIB_W-1:0] hit;
    hit = 4'h0;
    hit[0] = (adr == OFS_PORT_A);
    hit[1] = (adr == OFS_PORT_C);
    hit[2] = (adr == OFS_PORT_D);
    hit[3] = (adr == OFS_PORT_F);
    return hit;
  endfunction : port_of_addr

  assign pin_raw[0] = FIRST_NIBBLE_PORT_I;
  assign pin_raw[1] = SECOND_NIBBLE_PORT_I;
  assign pin_raw[2] = THIRD_NIBBLE_PORT_I;
  assign pin_raw[3] = SHARED_SERIAL_PORT_I;

  // Every pin level seen by software or the wake logic is filtered against chatter first.
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_sync
    nibble_pin_sync #(
      .W(NIB_W)
    ) u_sync (
      .clk_i(CLOCK_I),
      .rst_b_i(RST_B_I),
      .pin_i(pin_raw[p]),
      .level_o(pin_lvl[p])
    );
  end

  assign req = CYC_I & STB_I & ~st_r.ack;
  assign wr_en = req & WE_I & SEL_I[0];
  assign rd_en = req & ~WE_I;
  assign cmd_port = DAT_I[CMD_PORT_LSB +: 2];
  assign cmd_bit = DAT_I[CMD_BIT_LSB +: 2];
  assign cmd_op = bit_op_t'(DAT_I[CMD_OP_LSB +: 3]);

  always_comb begin
    logic [NIB_W-1:0] hit;
    hit = port_of_addr(ADR_I);
    st_nxt = st_r;
    st_nxt.ack = req;
    if (wr_en) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (hit[p]) begin
          st_nxt.latch[p] = DAT_I[NIB_W-1:0];
        end
      end
      if (ADR_I == OFS_BIT_CMD) begin
        unique case (cmd_op)
          OP_SET: begin
            st_nxt.latch[cmd_port] = st_r.latch[cmd_port] | bit_mask(cmd_bit);
          end
          OP_CLEAR: begin
            st_nxt.latch[cmd_port] = st_r.latch[cmd_port] & ~bit_mask(cmd_bit);
          end
          OP_BR_SET: begin
            st_nxt.pin_seen = |(pin_lvl[cmd_port] & bit_mask(cmd_bit));
            st_nxt.taken = |(pin_lvl[cmd_port] & bit_mask(cmd_bit));
          end
          OP_BR_CLEAR: begin
            st_nxt.pin_seen = |(pin_lvl[cmd_port] & bit_mask(cmd_bit));
            st_nxt.taken = ~|(pin_lvl[cmd_port] & bit_mask(cmd_bit));
          end
          default: begin
          end
        endcase
      end
      if (ADR_I == OFS_FUNC_SEL) begin
        st_nxt.func_sel = DAT_I[NIB_W-1:0];
      end
      if ((ADR_I == OFS_STANDBY) && DAT_I[STBY_HALT_BIT]) begin
        st_nxt.run_st = HALT_ST;
      end
    end
    // Wake is level sensitive, so bounce on the pin while halt is entered would wake at once.
    if ((st_r.run_st == HALT_ST) && pin_lvl[0][WAKE_BIT]) begin
      st_nxt.run_st = RUN_ST;
    end
    st_nxt.rdata = 32'h0000_0000;
    if (rd_en) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (hit[p]) begin
          st_nxt.rdata = {28'h000_0000, pin_lvl[p]};
        end
      end
      unique case (ADR_I)
        OFS_BIT_CMD: begin
          st_nxt.rdata[STAT_TAKEN_BIT] = st_r.taken;
          st_nxt.rdata[STAT_PIN_BIT] = st_r.pin_seen;
        end
        OFS_STANDBY: begin
          st_nxt.rdata[STBY_HALT_BIT] = (st_r.run_st == HALT_ST);
        end
        OFS_FUNC_SEL: begin
          st_nxt.rdata[NIB_W-1:0] = st_r.func_sel;
        end
        default: begin
        end
      endcase
    end
  end

  // Reset values are constants, so the pins reach their reset level the moment reset asserts.
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The shared pins hand their drive to the serial unit only for the functions selected.
  always_comb begin
    f_drive = st_r.latch[3];
    if (st_r.func_sel[FSEL_SER_IN]) begin
      f_drive[FSEL_SER_IN] = 1'b1;
    end
    if (st_r.func_sel[FSEL_SER_OUT]) begin
      f_drive[FSEL_SER_OUT] = SER_DATA_OUT_I;
    end
    if (st_r.func_sel[FSEL_SER_CLK]) begin
      f_drive[FSEL_SER_CLK] = SER_CLK_DRIVE_I ? SER_CLK_OUT_I : 1'b1;
    end
    if (st_r.func_sel[FSEL_EXT_INT]) begin
      f_drive[FSEL_EXT_INT] = 1'b1;
    end
  end

  // Pins only ever pull low; a high level comes from the resistor or the outside circuit.
  assign FIRST_NIBBLE_PORT_O = 4'h0;
  assign SECOND_NIBBLE_PORT_O = 4'h0;
  assign THIRD_NIBBLE_PORT_O = 4'h0;
  assign SHARED_SERIAL_PORT_O = 4'h0;
  assign FIRST_NIBBLE_PORT_OE_B_O = st_r.latch[0];
  assign SECOND_NIBBLE_PORT_OE_B_O = st_r.latch[1];
  assign THIRD_NIBBLE_PORT_OE_B_O = st_r.latch[2];
  assign SHARED_SERIAL_PORT_OE_B_O = f_drive;
  assign FIRST_NIBBLE_PULLUP_O = ~OPEN_DRAIN_A;
  assign SECOND_NIBBLE_PULLUP_O = ~OPEN_DRAIN_C;
  assign THIRD_NIBBLE_PULLUP_O = ~OPEN_DRAIN_D;
  assign SHARED_SERIAL_PULLUP_O = ~OPEN_DRAIN_F;

  assign SER_DATA_IN_O = st_r.func_sel[FSEL_SER_IN] ? pin_lvl[3][FSEL_SER_IN] : 1'b1;
  assign SER_CLK_IN_O = st_r.func_sel[FSEL_SER_CLK] ? pin_lvl[3][FSEL_SER_CLK] : 1'b1;
  assign EXT_INT_REQ_B_O = st_r.func_sel[FSEL_EXT_INT] ? pin_lvl[3][FSEL_EXT_INT] : 1'b1;
  assign HALTED_O = (st_r.run_st == HALT_ST);
  assign DAT_O = st_r.rdata;
  assign ACK_O = st_r.ack;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_B_I);

  sequence s_bus_req;
    CYC_I && STB_I && !ACK_O;
  endsequence

  sequence s_wr(logic [7:0] ofs);
    s_bus_req ##0 (WE_I && SEL_I[0] && ADR_I == ofs);
  endsequence

  property p_ack_single;
    s_bus_req |=> ACK_O ##1 !ACK_O;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("Bus answer did not last exactly one cycle.");

  property p_nibble_write;
    logic [3:0] d;
    (s_wr(OFS_PORT_A), d = DAT_I[3:0]) |=> FIRST_NIBBLE_PORT_OE_B_O == d;
  endproperty
  a_nibble_write: assert property (p_nibble_write)
    else $error("First port latches do not hold the written nibble.");

  property p_nibble_write_d;
    s_wr(OFS_PORT_D) |=> THIRD_NIBBLE_PORT_OE_B_O == $past(DAT_I[3:0]);
  endproperty
  a_nibble_write_d: assert property (p_nibble_write_d)
    else $error("Third port latches do not hold the written nibble.");

  property p_nibble_read;
    (s_bus_req ##0 (!WE_I && ADR_I == OFS_PORT_C)) |=>
      (ACK_O && DAT_O == {28'h000_0000, $past(pin_lvl[1])});
  endproperty
  a_nibble_read: assert property (p_nibble_read)
    else $error("Port read did not return the pin nibble.");

  property p_bit_set;
    (s_wr(OFS_BIT_CMD) ##0 (cmd_op == OP_SET && cmd_port == PORT_SEL_A)) |=>
      FIRST_NIBBLE_PORT_OE_B_O == ($past(FIRST_NIBBLE_PORT_OE_B_O) | $past(bit_mask(cmd_bit)));
  endproperty
  a_bit_set: assert property (p_bit_set)
    else $error("Bit set disturbed other bits or missed its bit.");

  property p_bit_clear;
    (s_wr(OFS_BIT_CMD) ##0 (cmd_op == OP_CLEAR && cmd_port == PORT_SEL_C)) |=>
      SECOND_NIBBLE_PORT_OE_B_O ==
        ($past(SECOND_NIBBLE_PORT_OE_B_O) & ~$past(bit_mask(cmd_bit)));
  endproperty
  a_bit_clear: assert property (p_bit_clear)
    else $error("Bit clear disturbed other bits or missed its bit.");

  property p_branch_clear;
    (s_wr(OFS_BIT_CMD) ##0 (cmd_op == OP_BR_CLEAR)) |=>
      st_r.taken == !$past(pin_lvl[cmd_port][cmd_bit]);
  endproperty
  a_branch_clear: assert property (p_branch_clear)
    else $error("Branch-if-clear result does not match the pin.");

  property p_wake;
    (HALTED_O && pin_lvl[0][WAKE_BIT]) |=> !HALTED_O;
  endproperty
  a_wake: assert property (p_wake)
    else $error("Wake pin high did not end the halted state.");

  property p_reset_levels;
    $rose(RST_B_I) |-> (FIRST_NIBBLE_PORT_OE_B_O == RST_LATCH_A &&
      SECOND_NIBBLE_PORT_OE_B_O == RST_LATCH_C && THIRD_NIBBLE_PORT_OE_B_O == RST_LATCH_D);
  endproperty
  a_reset_levels: assert property (p_reset_levels)
    else $error("Port levels after reset differ from the options.");

endmodule : quad_bit_io_ports

// ---- shared/quad_io_pkg.sv ----
// Package with register map, field layout, reset values and state types of the nibble ports.
package quad_io_pkg;

  localparam int NIB_W = 4;
  localparam int NUM_PORTS = 4;

  localparam logic [7:0] OFS_PORT_A = 8'h00;
  localparam logic [7:0] OFS_PORT_C = 8'h04;
  localparam logic [7:0] OFS_PORT_D = 8'h08;
  localparam logic [7:0] OFS_PORT_F = 8'h0C;
  localparam logic [7:0] OFS_BIT_CMD = 8'h10;
  localparam logic [7:0] OFS_STANDBY = 8'h14;
  localparam logic [7:0] OFS_FUNC_SEL = 8'h18;

  localparam logic [1:0] PORT_SEL_A = 2'h0;
  localparam logic [1:0] PORT_SEL_C = 2'h1;
  localparam logic [1:0] PORT_SEL_D = 2'h2;
  localparam logic [1:0] PORT_SEL_F = 2'h3;

  localparam int CMD_PORT_LSB = 0;
  localparam int CMD_BIT_LSB = 2;
  localparam int CMD_OP_LSB = 4;
  localparam int STAT_TAKEN_BIT = 0;
  localparam int STAT_PIN_BIT = 1;
  localparam int STBY_HALT_BIT = 0;
  localparam int WAKE_BIT = 3;

  localparam int FSEL_SER_IN = 0;
  localparam int FSEL_SER_OUT = 1;
  localparam int FSEL_SER_CLK = 2;
  localparam int FSEL_EXT_INT = 3;

  localparam logic [3:0] RST_LATCH_A = 4'hF;
  localparam logic [3:0] RST_LATCH_F = 4'hF;
  localparam logic [3:0] RST_FUNC_SEL = 4'h0;
  localparam logic [3:0] RST_PIN_LEVEL = 4'hF;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SET = 3'h1,
    OP_CLEAR = 3'h2,
    OP_BR_SET = 3'h3,
    OP_BR_CLEAR = 3'h4
  } bit_op_t;

  typedef enum logic [1:0] {
    RUN_ST = 2'b01,
    HALT_ST = 2'b10
  } run_state_t;

endpackage : quad_io_pkg

// ---- core/nibble_pin_sync.sv ----
// Three-stage pin synchroniser that accepts a new level once the last two stages agree.
`timescale 1ns/1ps
module nibble_pin_sync #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  import quad_io_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // The first stage feeds the second stage only, so a metastable value never reaches logic.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.level[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '{s1: '1, s2: '1, s3: '1, level: '1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.level;

endmodule : nibble_pin_sync

// ---- test/pin_board_model.sv ----
// Board model of the outside circuits that sit on the nibble port pins.
`timescale 1ns/1ps
module pin_board_model (
  input wire logic [15:0] oe_b_i,
  input wire logic [15:0] drv_i,
  input wire logic [15:0] ext_low_i,
  output logic [15:0] pin_o
);
  // Board resistors hold every released line high, so open-drain bits never float here.
  // An outside switch may still pull a released line low; a driven line follows the device unless the switch pulls it low.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pin_o[i] = (!oe_b_i[i]) ? (drv_i[i] & !ext_low_i[i]) : !ext_low_i[i];
    end
  end
endmodule : pin_board_model

// ---- test/tb_top.sv ----
// Self-checking bench of the nibble ports with a board model on the pins.
`timescale 1ns/1ps
module tb_top;
  import quad_io_pkg::*;
  typedef struct packed {logic [1:0] port; logic [3:0] data; logic [3:0] low;} row_t;
  logic clk;
  logic rst_b;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [31:0] dat_w;
  logic [31:0] dat_r;
  logic ack;
  logic [15:0] oe_b;
  logic [15:0] pull;
  logic [15:0] pin;
  logic [15:0] drv;
  logic [15:0] ext_low;
  logic ser_di;
  logic ser_ci;
  logic int_b;
  logic halted;
  logic [31:0] q;
  logic [3:0] sel;
  logic [3:0] sel_lane;
  logic ser_do;
  logic ser_co;
  logic ser_cdrv;
  int error_cnt;
  int n_tests;
  row_t rows [7] = '{'{2'd0, 4'hA, 4'h0}, '{2'd0, 4'h5, 4'h1}, '{2'd1, 4'h3, 4'h4},
    '{2'd1, 4'hF, 4'h8}, '{2'd2, 4'h0, 4'h0}, '{2'd2, 4'hC, 4'h2}, '{2'd3, 4'h6, 4'h0}};

  quad_bit_io_ports #(.OPEN_DRAIN_A(4'h5), .OPEN_DRAIN_C(4'h3), .RESET_HIGH_D(1'b0)) uut (
    .CLOCK_I(clk), .RST_B_I(rst_b), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
    .FIRST_NIBBLE_PORT_I(pin[3:0]), .FIRST_NIBBLE_PORT_O(drv[3:0]),
    .FIRST_NIBBLE_PORT_OE_B_O(oe_b[3:0]), .FIRST_NIBBLE_PULLUP_O(pull[3:0]),
    .SECOND_NIBBLE_PORT_I(pin[7:4]), .SECOND_NIBBLE_PORT_O(drv[7:4]),
    .SECOND_NIBBLE_PORT_OE_B_O(oe_b[7:4]), .SECOND_NIBBLE_PULLUP_O(pull[7:4]),
    .THIRD_NIBBLE_PORT_I(pin[11:8]), .THIRD_NIBBLE_PORT_O(drv[11:8]),
    .THIRD_NIBBLE_PORT_OE_B_O(oe_b[11:8]), .THIRD_NIBBLE_PULLUP_O(pull[11:8]),
    .SHARED_SERIAL_PORT_I(pin[15:12]), .SHARED_SERIAL_PORT_O(drv[15:12]),
    .SHARED_SERIAL_PORT_OE_B_O(oe_b[15:12]), .SHARED_SERIAL_PULLUP_O(pull[15:12]),
    .SER_DATA_OUT_I(ser_do), .SER_CLK_OUT_I(ser_co), .SER_CLK_DRIVE_I(ser_cdrv),
    .SER_DATA_IN_O(ser_di), .SER_CLK_IN_O(ser_ci), .EXT_INT_REQ_B_O(int_b), .HALTED_O(halted));

  pin_board_model board (.oe_b_i(oe_b), .drv_i(drv), .ext_low_i(ext_low), .pin_o(pin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  // The master never assumes a latency; it holds the request until ack is sampled.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= sel_lane;
    adr <= a;
    dat_w <= d;
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    @(posedge clk);
  endtask : wb

  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // Whole run is a few hundred cycles, so a wide margin still catches a hung handshake.
  initial begin
    #(8 * 20000);
    error_cnt++;
    stop_test();
  end

  initial begin
    int p;
    int n;
    logic [3:0] m;
    logic pv;
    logic [2:0] op;
    error_cnt = 0;
    n_tests = 0;
    rst_b = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat_w = 32'h0;
    sel = 4'h0;
    sel_lane = 4'hF;
    ser_do = 1'b0;
    ser_co = 1'b0;
    ser_cdrv = 1'b0;
    ext_low = 16'h0000;
    repeat (16) @(posedge clk);
    chk("oe during reset", 32'(oe_b), 32'h0000F0FF);
    chk("pull-up option", 32'(pull), 32'h000000CA);
    chk("halted at reset", 32'(halted), 32'h0);
    rst_b <= 1'b1;
    @(posedge clk);
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      p = rows[i].port;
      wb(1'b1, 8'(p * 4), 32'(rows[i].data), q);
      chk("latch nibble", 32'(oe_b[p*4+:4]), 32'(rows[i].data));
      ext_low[p*4+:4] <= rows[i].low;
      repeat (6) @(posedge clk);
      wb(1'b0, 8'(p * 4), 32'h0, q);
      chk("pin nibble", q, 32'(rows[i].data & ~rows[i].low));
      ext_low <= 16'h0000;
    end
    $display("nibble table done");
    for (p = 0; p < 3; p++) begin
      wb(1'b1, 8'(p * 4), 32'h0, q);
      m = 4'h0;
      for (int b = 0; b < 4; b++) begin
        wb(1'b1, OFS_BIT_CMD, 32'({OP_SET, 2'(b), 2'(p)}), q);
        m[b] = 1'b1;
        chk("bit set", 32'(oe_b[p*4+:4]), 32'(m));
      end
      wb(1'b1, OFS_BIT_CMD, 32'({OP_CLEAR, 2'd1, 2'(p)}), q);
      wb(1'b1, OFS_BIT_CMD, 32'({3'h7, 2'd2, 2'(p)}), q);
      chk("bit clear", 32'(oe_b[p*4+:4]), 32'h0000000D);
      wb(1'b1, 8'(p * 4), 32'h0000000F, q);
    end
    $display("bit set and clear done");
    ext_low <= 16'h0960;
    repeat (6) @(posedge clk);
    for (p = 0; p < 3; p++) begin
      for (int b = 0; b < 8; b++) begin
        op = (b < 4) ? OP_BR_SET : OP_BR_CLEAR;
        pv = !ext_low[p * 4 + b % 4];
        wb(1'b1, OFS_BIT_CMD, 32'({op, 2'(b % 4), 2'(p)}), q);
        wb(1'b0, OFS_BIT_CMD, 32'h0, q);
        chk("branch test", q, 32'({pv, (op == OP_BR_SET) ? pv : !pv}));
      end
    end
    $display("branch tests done");
    ext_low <= 16'h0008;
    repeat (6) @(posedge clk);
    wb(1'b1, OFS_STANDBY, 32'h1, q);
    repeat (8) @(posedge clk);
    chk("halt entered", 32'(halted), 32'h1);
    wb(1'b0, OFS_STANDBY, 32'h0, q);
    chk("halt readback", q, 32'h1);
    ext_low <= 16'h0000;
    n = 0;
    while (halted !== 1'b0 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk("wake by pin", 32'(halted), 32'h0);
    $display("standby test done");
    wb(1'b1, OFS_FUNC_SEL, 32'h9, q);
    ext_low <= 16'h9000;
    repeat (6) @(posedge clk);
    chk("serial in", 32'(ser_di), 32'h0);
    chk("ext int", 32'(int_b), 32'h0);
    wb(1'b1, OFS_FUNC_SEL, 32'h0, q);
    chk("serial in off", 32'(ser_di), 32'h1);
    chk("ext int off", 32'(int_b), 32'h1);
    ext_low <= 16'h0000;
    wb(1'b0, 8'h1C, 32'h0, q);
    chk("unmapped read", q, 32'h0);
    ser_cdrv <= 1'b1;
    wb(1'b1, OFS_FUNC_SEL, 32'h6, q);
    chk("serial drive low", 32'(oe_b[15:12]), 32'h0);
    repeat (6) @(posedge clk);
    chk("serial clock in low", 32'(ser_ci), 32'h0);
    ser_do <= 1'b1;
    ser_cdrv <= 1'b0;
    repeat (6) @(posedge clk);
    chk("serial drive released", 32'(oe_b[15:12]), 32'h6);
    chk("serial clock in high", 32'(ser_ci), 32'h1);
    wb(1'b1, OFS_FUNC_SEL, 32'h0, q);
    ser_do <= 1'b0;
    sel_lane = 4'hE;
    wb(1'b1, OFS_PORT_A, 32'h0, q);
    sel_lane = 4'hF;
    chk("write without lane", 32'(oe_b[3:0]), 32'hF);
    $display("shared pins and unmapped done");
    wb(1'b1, OFS_PORT_A, 32'h0, q);
    wb(1'b1, OFS_PORT_C, 32'h0, q);
    wb(1'b1, OFS_PORT_D, 32'hF, q);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk("oe in second reset", 32'(oe_b), 32'h0000F0FF);
    rst_b <= 1'b1;
    @(posedge clk);
    $display("second reset done");
    stop_test();
  end
endmodule : tb_top
